// *** hdl/adcrf_cfg.svh ***
// Constants for the converter result-format control block
// Assumes inclusion by the top module only
`ifndef ADCRF_CFG_SVH
`define ADCRF_CFG_SVH
`define ADCRF_OFF_CTRL0 12'h000
`define ADCRF_OFF_CTRL1 12'h004
`define ADCRF_OFF_RESH 12'h008
`define ADCRF_OFF_RESL 12'h00c
`define ADCRF_OFF_STAT 12'h010
`define ADCRF_OFF_TRIG 12'h014
`define ADCRF_C0_ON 0
`define ADCRF_C0_GO 1
`define ADCRF_C0_CHS_LO 2
`define ADCRF_C0_CHS_HI 6
`define ADCRF_C1_PREF_LO 0
`define ADCRF_C1_PREF_HI 1
`define ADCRF_C1_CS_LO 4
`define ADCRF_C1_CS_HI 6
`define ADCRF_C1_FM 7
`define ADCRF_CTRL_RESET 8'h00
`define ADCRF_CTRL0_MASK 8'h7f
`define ADCRF_CTRL1_MASK 8'hf3
`define ADCRF_CONV_CYCLES 4'hb
`endif

// *** hdl/adcrf_pkg.sv ***
// Types for the converter result-format control block
// Assumes adcrf_cfg.svh is on the include path
package adcrf_pkg;
    typedef struct packed {
        logic [9:0] value;
        logic valid;
    } adcrf_sample_t;
    typedef struct packed {
        logic [4:0] channel;
        logic [1:0] pref;
        logic [2:0] clk_sel;
        logic on;
        logic hold_discharge;
    } adcrf_analog_ctl_t;
    typedef enum logic [1:0] {
        ADCRF_IDLE = 2'b00,
        ADCRF_CONV = 2'b01,
        ADCRF_LOAD = 2'b11
    } adcrf_state_t;
endpackage

// *** hdl/adcrf_top.sv ***
// Result formatting and control registers of a 10-bit converter, APB slave
// Assumes one clock pclk; analog front end supplies a sample on done strobe
//
// Contract
// [RULE_01] Left-justified: result bits 1-0 go to low register bits 7-6, bits 5-0 carry none.
// [RULE_02] Right-justified: result bits 9-8 go to high register bits 1-0, bits 7-2 carry none.
// [RULE_03] Right-justified: result bits 7-0 go to low register bits 7-0.
// [RULE_04] Software waits a full acquisition time after a channel change before starting.
// [RULE_05] The hold capacitor is never discharged at the end of a conversion.
// [RULE_06] Unused six bit positions of the loaded result are written as zero.
// [RULE_07] Left-justified: result bits 9-2 go to the high register.
// [RULE_08] Setting start begins a conversion; hardware clears it on completion.
// [RULE_09] With the trigger selected, a first timer overflow sets the start flag. The code sets it only while the on bit is set.
// [RULE_10] Result registers are read/write and untouched by reset.
`include "adcrf_cfg.svh"
module adcrf_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic first_timer_overflow,
    input wire adcrf_pkg::adcrf_sample_t conv_sample,
    output adcrf_pkg::adcrf_analog_ctl_t analog_ctl,
    output logic conv_start,
    output logic conversion_done_flag
);
    import adcrf_pkg::*;

    logic [7:0] ctrl0_r, ctrl0_nxt;
    logic [7:0] ctrl1_r, ctrl1_nxt;
    logic trig_en_r, trig_en_nxt;
    logic done_r, done_nxt;
    logic [7:0] resh_r, resh_nxt;
    logic [7:0] resl_r, resl_nxt;
    logic [9:0] sample_r, sample_nxt;
    logic [3:0] cnt_r, cnt_nxt;
    adcrf_state_t state_r, state_nxt;
    logic tmr_s1_r, tmr_s2_r, tmr_s3_r;
    logic wr, rd, hit;
    logic tmr_edge;

    function automatic logic [15:0] adcrf_format(input logic [9:0] v, input logic right);
        if (right)
        begin
            adcrf_format = {6'h00, v[9:8], v[7:0]}; // [RULE_02] [RULE_03] [RULE_06]
        end
        else
        begin
            adcrf_format = {v[9:2], v[1:0], 6'h00}; // [RULE_07] [RULE_01] [RULE_06]
        end
    endfunction

    assign wr = psel && penable && pwrite;
    assign rd = psel && !pwrite;
    assign hit = (paddr == `ADCRF_OFF_CTRL0) || (paddr == `ADCRF_OFF_CTRL1) ||
        (paddr == `ADCRF_OFF_RESH) || (paddr == `ADCRF_OFF_RESL) ||
        (paddr == `ADCRF_OFF_STAT) || (paddr == `ADCRF_OFF_TRIG);
    assign pready = 1'b1;
    assign pslverr = psel && penable && !hit;
    assign tmr_edge = tmr_s2_r && !tmr_s3_r;

    // Timer overflow synchroniser
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tmr_s1_r <= 1'b0;
            tmr_s2_r <= 1'b0;
            tmr_s3_r <= 1'b0;
        end
        else
        begin
            tmr_s1_r <= first_timer_overflow;
            tmr_s2_r <= tmr_s1_r;
            tmr_s3_r <= tmr_s2_r;
        end
    end

    // Control, state machine and result loading
    always_comb
    begin
        logic [15:0] fmt;
        fmt = adcrf_format(sample_r, ctrl1_r[`ADCRF_C1_FM]);
        ctrl0_nxt = ctrl0_r;
        ctrl1_nxt = ctrl1_r;
        trig_en_nxt = trig_en_r;
        done_nxt = done_r;
        resh_nxt = resh_r;
        resl_nxt = resl_r;
        sample_nxt = sample_r;
        cnt_nxt = cnt_r;
        state_nxt = state_r;
        if (wr && paddr == `ADCRF_OFF_CTRL0)
        begin
            ctrl0_nxt = pwdata[7:0] & `ADCRF_CTRL0_MASK;
        end
        else if (wr && paddr == `ADCRF_OFF_CTRL1)
        begin
            ctrl1_nxt = pwdata[7:0] & `ADCRF_CTRL1_MASK;
        end
        else if (wr && paddr == `ADCRF_OFF_TRIG)
        begin
            trig_en_nxt = pwdata[0];
        end
        else if (wr && paddr == `ADCRF_OFF_STAT)
        begin
            done_nxt = 1'b0;
        end
        if (wr && paddr == `ADCRF_OFF_RESH)
        begin
            resh_nxt = pwdata[7:0]; // [RULE_10]
        end
        if (wr && paddr == `ADCRF_OFF_RESL)
        begin
            resl_nxt = pwdata[7:0]; // [RULE_10]
        end
        if (trig_en_r && tmr_edge && ctrl0_nxt[`ADCRF_C0_ON])
        begin
            ctrl0_nxt[`ADCRF_C0_GO] = 1'b1; // [RULE_09]
        end
        case (state_r)
            ADCRF_IDLE:
            begin
                if (ctrl0_r[`ADCRF_C0_GO] && ctrl0_r[`ADCRF_C0_ON])
                begin
                    state_nxt = ADCRF_CONV; // [RULE_08]
                    cnt_nxt = `ADCRF_CONV_CYCLES;
                end
                else if (ctrl0_r[`ADCRF_C0_GO])
                begin
                    ctrl0_nxt[`ADCRF_C0_GO] = 1'b0; // [RULE_08]
                end
            end
            ADCRF_CONV:
            begin
                if (!ctrl0_r[`ADCRF_C0_ON] || !ctrl0_nxt[`ADCRF_C0_GO])
                begin
                    state_nxt = ADCRF_LOAD;
                end
                else if (conv_sample.valid)
                begin
                    sample_nxt = conv_sample.value;
                    state_nxt = ADCRF_LOAD;
                end
                else if (cnt_r != 4'h0)
                begin
                    cnt_nxt = cnt_r - 4'h1;
                end
            end
            ADCRF_LOAD:
            begin
                resh_nxt = fmt[15:8];
                resl_nxt = fmt[7:0];
                ctrl0_nxt[`ADCRF_C0_GO] = 1'b0; // [RULE_08]
                done_nxt = 1'b1;
                state_nxt = ADCRF_IDLE;
            end
            default:
            begin
                state_nxt = ADCRF_IDLE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl0_r <= `ADCRF_CTRL_RESET;
            ctrl1_r <= `ADCRF_CTRL_RESET;
            trig_en_r <= 1'b0;
            done_r <= 1'b0;
            cnt_r <= 4'h0;
            state_r <= ADCRF_IDLE;
        end
        else
        begin
            ctrl0_r <= ctrl0_nxt;
            ctrl1_r <= ctrl1_nxt;
            trig_en_r <= trig_en_nxt;
            done_r <= done_nxt;
            cnt_r <= cnt_nxt;
            state_r <= state_nxt;
        end
    end

    // Result storage, not reset
    always_ff @(posedge pclk)
    begin
        resh_r <= resh_nxt; // [RULE_10]
        resl_r <= resl_nxt;
        sample_r <= sample_nxt;
    end

    // Read data
    always_comb
    begin
        prdata = 32'h0000_0000;
        if (rd && paddr == `ADCRF_OFF_CTRL0)
        begin
            prdata[7:0] = ctrl0_r;
        end
        else if (rd && paddr == `ADCRF_OFF_CTRL1)
        begin
            prdata[7:0] = ctrl1_r;
        end
        else if (rd && paddr == `ADCRF_OFF_RESH)
        begin
            prdata[7:0] = resh_r;
        end
        else if (rd && paddr == `ADCRF_OFF_RESL)
        begin
            prdata[7:0] = resl_r;
        end
        else if (rd && paddr == `ADCRF_OFF_STAT)
        begin
            prdata[1:0] = {done_r, state_r != ADCRF_IDLE};
        end
        else if (rd && paddr == `ADCRF_OFF_TRIG)
        begin
            prdata[0] = trig_en_r;
        end
    end

    always_comb
    begin
        analog_ctl.channel = ctrl0_r[`ADCRF_C0_CHS_HI:`ADCRF_C0_CHS_LO];
        analog_ctl.pref = ctrl1_r[`ADCRF_C1_PREF_HI:`ADCRF_C1_PREF_LO];
        analog_ctl.clk_sel = ctrl1_r[`ADCRF_C1_CS_HI:`ADCRF_C1_CS_LO];
        analog_ctl.on = ctrl0_r[`ADCRF_C0_ON];
        analog_ctl.hold_discharge = 1'b0; // [RULE_05]
    end
    assign conv_start = (state_r == ADCRF_CONV);
    assign conversion_done_flag = done_r;
endmodule

// *** verification/adcrf_analog_model.sv ***
// Analog front end, answers a conversion after lat cycles
// Assumes conv_start from adcrf_top
module adcrf_analog_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic conv_start,
    input wire logic [9:0] level,
    input wire logic [3:0] lat,
    output adcrf_pkg::adcrf_sample_t conv_sample
);
    logic [3:0] cnt;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt <= 4'h0;
            conv_sample <= '0;
        end
        else if (conv_start && cnt == lat)
            conv_sample <= '{level, 1'b1};
        else
        begin
            cnt <= conv_start ? cnt + 4'h1 : 4'h0;
            conv_sample <= '{~conv_sample.value, 1'b0};
        end
    end
endmodule

// *** verification/adcrf_sva.sv ***
// Port checker of the converter format block
// Assumes a bind onto adcrf_top
module adcrf_sva (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pslverr,
    input wire adcrf_pkg::adcrf_sample_t conv_sample,
    input wire adcrf_pkg::adcrf_analog_ctl_t analog_ctl,
    input wire logic conv_start,
    input wire logic conversion_done_flag
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic acc;
    assign acc = psel && penable;
    property p_hold; !analog_ctl.hold_discharge; endproperty
    a_hold: assert property (p_hold) else $error("hold discharged");
    property p_on; $rose(conv_start) |-> analog_ctl.on; endproperty
    a_on: assert property (p_on) else $error("start while off");
    property p_end; conv_start && conv_sample.valid |=> !conv_start ##1 conversion_done_flag; endproperty
    a_end: assert property (p_end) else $error("no completion");
    property p_off; !analog_ctl.on |=> !conv_start; endproperty
    a_off: assert property (p_off) else $error("busy while off");
    property p_clr; acc && pwrite && paddr == 12'h010 && !conv_start && !$past(conv_start)
        |=> !conversion_done_flag; endproperty
    a_clr: assert property (p_clr) else $error("done not cleared");
    property p_err; acc && paddr > 12'h014 |-> pslverr && prdata == 32'h0; endproperty
    a_err: assert property (p_err) else $error("unmapped accepted");
    property p_upper; acc && !pwrite |-> prdata[31:8] == 24'h0; endproperty
    a_upper: assert property (p_upper) else $error("upper read bits set");
    property p_chan; !(acc && pwrite && paddr == 12'h000) |=> $stable(analog_ctl.channel); endproperty
    a_chan: assert property (p_chan) else $error("channel moved");
    c_conv: cover property ($fell(conv_start));
    c_done: cover property ($rose(conversion_done_flag));
    c_err: cover property (acc && pslverr);
endmodule
bind adcrf_top adcrf_sva adcrf_sva_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .prdata, .pslverr,
    .conv_sample, .analog_ctl, .conv_start, .conversion_done_flag);

// *** verification/adcrf_top_tb.sv ***
// Bench of the converter format block
// Assumes adcrf_top, the analog model and the checker
module adcrf_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk, presetn, psel, penable, pwrite, tmr, pslverr, pready, conv_start, done, fm;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [9:0] level, v;
    logic [3:0] lat;
    logic [6:0] ctl;
    logic [7:0] c1;
    logic [15:0] e;
    adcrf_pkg::adcrf_sample_t conv_sample;
    adcrf_pkg::adcrf_analog_ctl_t analog_ctl;
    int fail_count = 0;
    int checked = 0;
    adcrf_top adcrf_top_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .first_timer_overflow(tmr), .conv_sample, .analog_ctl, .conv_start, .conversion_done_flag(done));
    adcrf_analog_model adcrf_analog_model_inst (.pclk, .presetn, .conv_start, .level, .lat, .conv_sample);
    initial
    begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    function automatic logic [15:0] fmt(input logic f, input logic [9:0] r);
        return f ? {6'h0, r} : {r, 6'h0};
    endfunction
    task automatic tally_and_finish();
        if (fail_count == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            fail_count++;
            $display("unexpected at %0t: %h not %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        repeat (20)
        begin
            @(posedge pclk);
            if (pready === 1'b1)
                break;
        end
        chk({31'h0, pready}, 32'h1);
        if (pready !== 1'b1)
            tally_and_finish();
        q = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    initial
    begin
        {psel, penable, pwrite, tmr, presetn} = 5'h0;
        paddr = 12'h0;
        pwdata = 32'h0;
        level = 10'h0;
        lat = 4'h1;
        void'($urandom(77276));
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        for (int a = 0; a < 28; a += 4)
        begin
            apb(1'b0, 12'(a), 32'h0);
            if (a != 8 && a != 12)
                chk(q, 32'h0);
        end
        apb(1'b1, 12'h00c, 32'h5a);
        apb(1'b0, 12'h00c, 32'h0);
        chk(q, 32'h5a);
        apb(1'b1, 12'h014, 32'h1);
        for (int i = 0; i < 12; i++)
        begin
            fm = i < 2 ? 1'(i) : 1'($urandom);
            v = i < 2 ? 10'h3ff : i == 2 ? 10'h0 : 10'($urandom);
            e = fmt(fm, v);
            level <= v;
            lat <= 4'($urandom_range(8));
            ctl = {5'($urandom), 2'h1};
            c1 = {fm, 3'($urandom), 2'h3, 2'($urandom)};
            apb(1'b1, 12'h004, {24'h0, c1});
            apb(1'b1, 12'h000, {24'h0, 1'b1, ctl});
            repeat (8) @(posedge pclk);
            chk({20'h0, analog_ctl}, {20'h0, ctl[6:2], c1[1:0], c1[6:4], 2'h2});
            if (i % 2)
            begin
                tmr <= 1'b1;
                repeat (3) @(posedge pclk);
                tmr <= 1'b0;
            end
            else
                apb(1'b1, 12'h000, {25'h0, ctl | 7'h2});
            repeat (40)
            begin
                apb(1'b0, 12'h010, 32'h0);
                if (q[1] === 1'b1)
                    break;
            end
            chk(q, 32'h2);
            if (q !== 32'h2)
                tally_and_finish();
            apb(1'b0, 12'h000, 32'h0);
            chk(q, {25'h0, ctl});
            apb(1'b0, 12'h008, 32'h0);
            chk(q, {24'h0, e[15:8]});
            apb(1'b0, 12'h00c, 32'h0);
            chk(q, {24'h0, e[7:0]});
            apb(1'b1, 12'h010, 32'h0);
        end
        // Mid-run reset keeps the results
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, 12'h008, 32'h0);
        chk(q, {24'h0, e[15:8]});
        apb(1'b0, 12'h00c, 32'h0);
        chk(q, {24'h0, e[7:0]});
        apb(1'b0, 12'h000, 32'h0);
        chk(q, 32'h0);
        tally_and_finish();
    end
endmodule
